// >>> gesture_sample_pkg.sv
/*
 * Constants shared by the gesture sample sequencer.
 * Assumes one 250 MHz clock and a synchronous active-low reset.
 */
package gesture_sample_pkg;

	// ****************************************
	// Array geometry
	// ****************************************
	localparam int ARRAY_ROWS = 6;
	localparam int ARRAY_COLS = 10;
	localparam int PIXEL_COUNT = ARRAY_ROWS * ARRAY_COLS;
	localparam logic [5:0] LAST_PIXEL = 6'h3B;
	localparam int PIXEL_WIDTH = 16;

	// ****************************************
	// LED drive
	// ****************************************
	localparam logic [3:0] PWM_LAST_STEP = 4'hF;
	localparam logic [3:0] PWM_FIRST_STEP = 4'h0;
	localparam logic [2:0] PULSE_FIRST = 3'h0;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [5:0] PIXEL_RESET = 6'h00;
	localparam logic [15:0] DATA_RESET = 16'h0000;

	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_DARK,
		SEQ_PULSE,
		SEQ_LIT,
		SEQ_DONE
	} seq_state_type;

endpackage : gesture_sample_pkg

// >>> gesture_sample_sequencer.sv
/*
 * Sample sequencer: LED PWM pulse pattern, ambient-rejecting array scan,
 * sample-complete interrupt and host interface strap.
 * Assumes a synchronous analog front end that presents the pixel chosen by
 * pixelSel on pixelIn in the same cycle, and a host read strobe for status.
 */
// How it works
// [RL1] Interrupt pin pulled low once a whole sample sequence completes.
// [RL2] Interrupt stays inactive until status has been read once; host must do that.
// [RL3] Host watches the interrupt and reads results after it falls.
// [RL4] Strap picks host interface: high means I2C, low means SPI.
// [RL5] External sync input times LED flashes so two sensors never overlap.
// [RL6] LED gate PWM duty set in sixteenths, one sixteenth to fully on.
// [RL7] LED pulsed a programmed number of times, same pattern every sample.
// [RL8] Each of 60 pixels measured lit minus dark, removing ambient light.
// [RL9] LED gate is push-pull, polarity selectable for p- or n-channel FET.
// [RL10] Status read after a completed sample releases interrupt high.
`timescale 1ns/1ps
`default_nettype none

module gesture_sample_sequencer
	import gesture_sample_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Sequence control
	input wire logic runEnable,
	input wire logic syncEnable,
	input wire logic syncIn,
	input wire logic [3:0] dutyCode,
	input wire logic [2:0] pulseCount,
	input wire logic ledActiveLow,
	// Strap
	input wire logic selPin,
	output logic hostIfSpi,
	output logic strapValid,
	// LED drive
	output logic ledGatePwm,
	// Photodiode array
	output logic [5:0] pixelSel,
	input wire logic [15:0] pixelIn,
	// Host side
	input wire logic statusRead,
	output logic eocStatus,
	input wire logic [5:0] resultAddr,
	output logic [15:0] resultData,
	// Interrupt pin, open drain
	output logic intPinOut,
	output logic intPinOe
);

	// ****************************************
	// State
	// ****************************************
	seq_state_type state_r;
	logic [5:0] pixel_r;
	logic [3:0] pwmCnt_r;
	logic [2:0] pulseCnt_r;
	logic syncPrev_r;
	logic led_r;
	logic armed_r;
	logic eoc_r;
	logic spi_r;
	logic strapDone_r;
	logic [15:0] readData_r;
	logic [15:0] darkMem [PIXEL_COUNT];
	logic [15:0] resultMem [PIXEL_COUNT];

	logic syncRise;
	logic startOk;
	logic sampleDone;
	logic ledOnNxt;
	logic [15:0] darkNow;
	logic [15:0] diffNxt;

	function automatic logic [15:0] sat_sub(input logic [15:0] lit, input logic [15:0] dark);
		sat_sub = (lit > dark) ? 16'(lit - dark) : DATA_RESET;
	endfunction : sat_sub

	assign syncRise = syncIn && !syncPrev_r;
	assign startOk = runEnable && (!syncEnable || syncRise); // see [RL5]
	assign sampleDone = (state_r == SEQ_DONE);
	assign darkNow = darkMem[pixel_r];
	assign diffNxt = sat_sub(pixelIn, darkNow); // see [RL8]
	assign ledOnNxt = (state_r == SEQ_PULSE) && (pwmCnt_r <= dutyCode); // see [RL6]

	// ****************************************
	// Sync edge detect
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			syncPrev_r <= 1'b0;
		end else begin
			syncPrev_r <= syncIn;
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= SEQ_IDLE;
			pixel_r <= PIXEL_RESET;
			pwmCnt_r <= PWM_FIRST_STEP;
			pulseCnt_r <= PULSE_FIRST;
		end else begin
			case (state_r)
				SEQ_IDLE: begin
					pixel_r <= PIXEL_RESET;
					if (startOk) begin
						state_r <= SEQ_DARK; // see [RL5]
					end
				end
				SEQ_DARK: begin
					if (pixel_r == LAST_PIXEL) begin
						pixel_r <= PIXEL_RESET;
						pwmCnt_r <= PWM_FIRST_STEP;
						pulseCnt_r <= PULSE_FIRST;
						state_r <= SEQ_PULSE;
					end else begin
						pixel_r <= pixel_r + 6'h01;
					end
				end
				SEQ_PULSE: begin
					pwmCnt_r <= pwmCnt_r + 4'h1;
					if (pwmCnt_r == PWM_LAST_STEP) begin
						if (pulseCnt_r == pulseCount) begin
							state_r <= SEQ_LIT; // see [RL7]
						end else begin
							pulseCnt_r <= pulseCnt_r + 3'h1;
						end
					end
				end
				SEQ_LIT: begin
					if (pixel_r == LAST_PIXEL) begin
						pixel_r <= PIXEL_RESET;
						state_r <= SEQ_DONE;
					end else begin
						pixel_r <= pixel_r + 6'h01;
					end
				end
				SEQ_DONE: begin
					state_r <= SEQ_IDLE; // see [RL7]
				end
				default: begin
					state_r <= SEQ_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Pixel memories
	// ****************************************
	always_ff @(posedge clk) begin
		if (state_r == SEQ_DARK) begin
			darkMem[pixel_r] <= pixelIn; // see [RL8]
		end
		if (state_r == SEQ_LIT) begin
			resultMem[pixel_r] <= diffNxt; // see [RL8]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			readData_r <= DATA_RESET;
		end else if (resultAddr <= LAST_PIXEL) begin
			readData_r <= resultMem[resultAddr];
		end else begin
			readData_r <= DATA_RESET;
		end
	end

	// ****************************************
	// LED gate
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			led_r <= 1'b0;
		end else begin
			led_r <= ledOnNxt ^ ledActiveLow; // see [RL9]
		end
	end

	// ****************************************
	// Interrupt
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			armed_r <= 1'b0;
		end else if (statusRead) begin
			armed_r <= 1'b1; // see [RL2]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			eoc_r <= 1'b0;
		end else if (sampleDone) begin
			eoc_r <= 1'b1; // see [RL1]
		end else if (statusRead) begin
			eoc_r <= 1'b0; // see [RL10]
		end
	end

	// ****************************************
	// Strap capture
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			strapDone_r <= 1'b0;
			spi_r <= 1'b0;
		end else if (!strapDone_r) begin
			strapDone_r <= 1'b1;
			spi_r <= !selPin; // see [RL4]
		end
	end

	assign hostIfSpi = spi_r;
	assign strapValid = strapDone_r;
	assign ledGatePwm = led_r;
	assign pixelSel = pixel_r;
	assign eocStatus = eoc_r;
	assign resultData = readData_r;
	assign intPinOut = 1'b0;
	assign intPinOe = armed_r && eoc_r; // see [RL1] see [RL3]

	// ****************************************
	// Checks
	// ****************************************
	a_int_needs_arm: assert property (@(posedge clk) disable iff (!rst_n) // see [RL2]
		(!armed_r && !statusRead) |=> !intPinOe)
		else $error("interrupt active before first status read");

	a_int_on_done: assert property (@(posedge clk) disable iff (!rst_n) // see [RL1]
		(sampleDone && (armed_r || statusRead)) |=> intPinOe)
		else $error("interrupt not asserted after sample done");

	a_int_release: assert property (@(posedge clk) disable iff (!rst_n) // see [RL10]
		(statusRead && !sampleDone) |=> !intPinOe)
		else $error("interrupt not released by status read");

	a_pwm_duty: assert property (@(posedge clk) disable iff (!rst_n) // see [RL6]
		(state_r == SEQ_PULSE) |=>
		(ledGatePwm == (($past(pwmCnt_r) <= $past(dutyCode)) ^ $past(ledActiveLow))))
		else $error("led gate duty wrong");

	a_led_dark: assert property (@(posedge clk) disable iff (!rst_n) // see [RL8]
		(state_r == SEQ_DARK) |=> ledGatePwm == $past(ledActiveLow))
		else $error("led lit during dark scan");

	a_pulse_count: assert property (@(posedge clk) disable iff (!rst_n) // see [RL7]
		(state_r == SEQ_PULSE) ##1 (state_r == SEQ_LIT) |-> $past(pulseCnt_r) == $past(pulseCount))
		else $error("wrong number of led pulses");

	a_sync_wait: assert property (@(posedge clk) disable iff (!rst_n) // see [RL5]
		(state_r == SEQ_IDLE && syncEnable && !syncRise) |=> state_r == SEQ_IDLE)
		else $error("sample started without sync edge");

	a_strap_hold: assert property (@(posedge clk) disable iff (!rst_n) // see [RL4]
		strapDone_r |=> $stable(hostIfSpi) && strapValid)
		else $error("strap changed after capture");

	a_scan_len: assert property (@(posedge clk) disable iff (!rst_n) // see [RL8]
		(state_r == SEQ_LIT && pixel_r == LAST_PIXEL) |=> state_r == SEQ_DONE ##1 state_r == SEQ_IDLE)
		else $error("lit scan length wrong");

endmodule : gesture_sample_sequencer

`default_nettype wire

// >>> host_model.sv
/*
 * Host model: status read strobe and interrupt line level.
 * Assumes the bench requests status reads through readReq.
 */
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// Clock
	input wire logic clk,
	// Bench request
	input wire logic readReq,
	// Device pins
	input wire logic intPinOut,
	input wire logic intPinOe,
	output logic statusRead,
	output logic intLevel
);
	// Pull-up on the open-drain line
	assign intLevel = intPinOe ? intPinOut : 1'b1;
	always @(negedge clk) begin
		statusRead <= readReq;
	end
endmodule : host_model
`default_nettype wire

// >>> test_gesture_sample_sequencer.sv
/*
 * Testbench of the gesture sample sequencer.
 * Assumes the host model and a simple lit/dark front end model.
 */
`timescale 1ns/1ps
`default_nettype none
module test_gesture_sample_sequencer;
	import gesture_sample_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, runEnable = 1'b0, syncEnable = 1'b0, syncIn = 1'b0;
	logic ledActiveLow = 1'b0, readReq = 1'b0, clrCount = 1'b0, litPhase = 1'b0, selPin = 1'b0;
	logic statusRead, intLevel, intPinOut, intPinOe, hostIfSpi, strapValid, ledGatePwm, eocStatus;
	logic [3:0] dutyCode = 4'h0;
	logic [2:0] pulseCount = 3'h0;
	logic [5:0] pixelSel, resultAddr = 6'h00;
	logic [15:0] pixelIn, resultData;
	int n_mismatch = 0, checked = 0, litCount = 0;

	// ****************************************
	// Models
	// ****************************************
	initial forever #2 clk = ~clk;
	assign pixelIn = litPhase ? 16'h0100 + {10'h000, pixelSel} : 16'h0010;
	always @(posedge clk) begin
		if (clrCount) begin
			litCount <= 0;
			litPhase <= 1'b0;
		end else if (ledGatePwm !== ledActiveLow) begin
			litCount <= litCount + 1;
			litPhase <= 1'b1;
		end
	end
	gesture_sample_sequencer i_gesture_sample_sequencer (.clk(clk), .rst_n(rst_n), .runEnable(runEnable),
		.syncEnable(syncEnable), .syncIn(syncIn), .dutyCode(dutyCode), .pulseCount(pulseCount),
		.ledActiveLow(ledActiveLow), .selPin(selPin), .hostIfSpi(hostIfSpi), .strapValid(strapValid),
		.ledGatePwm(ledGatePwm), .pixelSel(pixelSel), .pixelIn(pixelIn), .statusRead(statusRead),
		.eocStatus(eocStatus), .resultAddr(resultAddr), .resultData(resultData), .intPinOut(intPinOut),
		.intPinOe(intPinOe));
	host_model i_host_model (.clk(clk), .readReq(readReq), .intPinOut(intPinOut), .intPinOe(intPinOe),
		.statusRead(statusRead), .intLevel(intLevel));

	// ****************************************
	// Tasks
	// ****************************************
	task cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task status_read;
		@(negedge clk);
		readReq <= 1'b1;
		@(negedge clk);
		readReq <= 1'b0;
		repeat (2) @(negedge clk);
	endtask : status_read
	task run_sample(input logic [3:0] d, input logic [2:0] p, input logic act);
		int i;
		@(negedge clk);
		dutyCode = d;
		pulseCount = p;
		ledActiveLow = act;
		clrCount = 1'b1;
		runEnable = 1'b1;
		@(negedge clk);
		clrCount = 1'b0;
		runEnable = 1'b0;
		for (i = 0; i < 900 && eocStatus !== 1'b1; i++) @(negedge clk);
		cmp(16'(eocStatus), 16'h0001);
		cmp(16'(litCount), 16'((d + 1) * (p + 1)));
	endtask : run_sample
	task check_results;
		resultAddr = 6'h00;
		repeat (2) @(negedge clk);
		cmp(resultData, 16'h00F0);
		resultAddr = 6'h3B;
		repeat (2) @(negedge clk);
		cmp(resultData, 16'h012B);
		resultAddr = 6'h3C;
		repeat (2) @(negedge clk);
		cmp(resultData, 16'h0000);
	endtask : check_results
	task sync_test;
		@(negedge clk);
		syncEnable = 1'b1;
		runEnable = 1'b1;
		repeat (300) @(negedge clk);
		cmp(16'(eocStatus), 16'h0000);
		syncIn = 1'b1;
		@(negedge clk);
		runEnable = 1'b0;
		repeat (300) @(negedge clk);
		cmp(16'(eocStatus), 16'h0001);
	endtask : sync_test
	task strap_test;
		@(negedge clk);
		syncEnable = 1'b0;
		syncIn = 1'b0;
		selPin = 1'b1;
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		cmp(16'({strapValid, hostIfSpi}), 16'h0002);
		run_sample(4'h3, 3'h1, 1'b0);
		cmp(16'({eocStatus, intLevel}), 16'h0003);
	endtask : strap_test
	task finish_test;
		if (n_mismatch == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		cmp(16'({strapValid, hostIfSpi}), 16'h0003);
		run_sample(4'h0, 3'h0, 1'b0);
		cmp(16'({eocStatus, intLevel}), 16'h0003);
		status_read;
		cmp(16'({eocStatus, intLevel}), 16'h0001);
		run_sample(4'h5, 3'h2, 1'b0);
		cmp(16'(intLevel), 16'h0000);
		check_results;
		status_read;
		cmp(16'(intLevel), 16'h0001);
		run_sample(4'hF, 3'h7, 1'b1);
		status_read;
		sync_test;
		strap_test;
		finish_test;
	end
	initial begin
		#100000;
		n_mismatch++;
		finish_test;
	end
endmodule : test_gesture_sample_sequencer
`default_nettype wire
